//--- lin_sync_cfg.svh
`ifndef LIN_SYNC_CFG_SVH
`define LIN_SYNC_CFG_SVH
// Register addresses (16-bit special-function space)
`define ADDR_DIV_HIGH      16'hA093
`define ADDR_DIV_LOW       16'hA094
`define ADDR_IRQ_FLAGS     16'hA095
`define ADDR_IRQ_ENABLES   16'hA096
`define ADDR_TO_CONFIG     16'hA0A0
`define ADDR_TX_TO_LOW     16'hA0A1
`define ADDR_TX_TO_HIGH    16'hA0A2
`define ADDR_RX_TO_LOW     16'hA0A3
`define ADDR_RX_TO_HIGH    16'hA0A4
`define ADDR_MODE          16'hA0B0
// Flag register bit positions
`define FLG_AUTO_UPDATE_DONE_FLAG           3
`define FLG_RSI            1
// Config register bit positions
`define CFG_RX_LSB         7
`define CFG_BREAK_EXIT     6
`define CFG_RX_FLAG        3
`define CFG_TX_FLAG        2
`define CFG_RX_EN          1
`define CFG_TX_EN          0
// Mode register bit positions
`define MODE_MASTER        0
`define MODE_AUTO_SYNC     1
// Reset values and constants
`define BYTE_ZERO          8'h00
`define DIV_RESET          16'h0001
`define SYNC_BITS          8
`define COUNT_ONE          17'h00001
`endif

//--- lin_sync_pkg.sv
package lin_sync_pkg;
  typedef enum logic [1:0] {SYNC_IDLE, SYNC_BREAK, SYNC_WAIT, SYNC_MEASURE} sync_state_type;
endpackage : lin_sync_pkg

//--- stuck_if.sv
`timescale 1ns/1ps
`default_nettype none
interface stuck_if #(parameter int WIDTH = 17);
  logic             line_dominant;
  logic [WIDTH-1:0] limit;
  logic             fault;
  modport watcher (input line_dominant, input limit, output fault);
  modport owner   (output line_dominant, output limit, input fault);
endinterface : stuck_if
`default_nettype wire

//--- stuck_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "lin_sync_cfg.svh"
// Counts continuous dominant cycles; one-cycle fault pulse at limit+1
module stuck_timer #(
  parameter int WIDTH = 17
) (
  input  wire logic clk,
  input  wire logic reset_n,
  stuck_if.watcher  port
);
  logic [WIDTH-1:0] count;
  logic             fired;
  // ==========================================================
  // Dominant counter, restarts on each recessive level
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      count <= '0;
      fired <= 1'b0;
      port.fault <= 1'b0;
    end else if (!port.line_dominant) begin // see RULE_12
      count <= '0;
      fired <= 1'b0;
      port.fault <= 1'b0;
    end else begin
      port.fault <= 1'b0;
      if (!fired) begin
        if (count == port.limit) begin // Limit+1 clocks of dominance, see RULE_11
          fired <= 1'b1;
          port.fault <= 1'b1;
        end else begin
          count <= count + WIDTH'(`COUNT_ONE);
        end
      end
    end
  end
endmodule : stuck_timer
`default_nettype wire

//--- lin_sync_top.sv
// Operation
// RULE_01: Measured divider readable, read-only sixteen bits
// RULE_02: Measured divider valid only in slave
// RULE_03: Bit rate is clock over divider+1
// RULE_04: Break plus sync sets flag, stores divider
// RULE_05: Software may copy measured into setting
// RULE_06: Auto update copies divider, sets flag
// RULE_07: Rx timeout seventeen bits, split registers
// RULE_08: Break exit on rx fault option
// RULE_09: Rx fault flag sticky, enable gates irq
// RULE_10: Tx fault flag sticky, enable gates irq
// RULE_11: Tx timeout is value+1 clocks
// RULE_12: Continuous dominant beyond timeout raises fault
// RULE_13: Write one clears flag, zero keeps
`timescale 1ns/1ps
`default_nettype none
`include "lin_sync_cfg.svh"
module lin_sync_top #(
  parameter int DIV_WIDTH = 16,
  parameter int RX_WIDTH  = 17
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RESET_N,
  input  wire logic [15:0] ADDR,
  input  wire logic [7:0]  WDATA,
  input  wire logic        WR_STB,
  input  wire logic        RD_STB,
  output var  logic [7:0]  RDATA,
  input  wire logic        RXD,
  input  wire logic        TXD,
  output var  logic        BIT_TICK,
  output var  logic        BREAK_ACTIVE,
  output var  logic        IRQ
);
  logic [DIV_WIDTH-1:0]   divider_setting;
  logic [DIV_WIDTH-1:0]   measured_divider;
  logic [DIV_WIDTH-1:0]   baud_count;
  logic [7:0]             flags;
  logic [7:0]             enables;
  logic                   rx_stuck_fault_flag;
  logic                   tx_stuck_fault_flag;
  logic                   rx_stuck_irq_enable;
  logic                   tx_stuck_irq_enable;
  logic                   break_exit_on_rx_fault;
  logic [RX_WIDTH-1:0]    rx_stuck_timeout_value;
  logic [DIV_WIDTH-1:0]   tx_stuck_timeout_value;
  logic                   master_mode;
  logic                   auto_sync_update_enable;
  lin_sync_pkg::sync_state_type state;
  logic [DIV_WIDTH+3-1:0] low_count;
  logic [DIV_WIDTH+3-1:0] sync_span;
  logic [3:0]             edges;
  logic                   rxd_prev;
  logic                   sync_done;
  logic                   wr_flags;
  logic                   wr_cfg;
  logic [DIV_WIDTH-1:0]   break_min;

  stuck_if #(.WIDTH(RX_WIDTH)) rx_link ();
  stuck_if #(.WIDTH(RX_WIDTH)) tx_link ();

  // ==========================================================
  // Fault supervisors
  assign rx_link.line_dominant = !RXD;
  assign rx_link.limit         = rx_stuck_timeout_value; // see RULE_07
  assign tx_link.line_dominant = !TXD;
  assign tx_link.limit         = {1'b0, tx_stuck_timeout_value}; // see RULE_11

  stuck_timer #(.WIDTH(RX_WIDTH)) rx_timer (
    .clk     (CORE_CLK),
    .reset_n (RESET_N),
    .port    (rx_link.watcher)
  );
  stuck_timer #(.WIDTH(RX_WIDTH)) tx_timer (
    .clk     (CORE_CLK),
    .reset_n (RESET_N),
    .port    (tx_link.watcher)
  );

  assign wr_flags = WR_STB && (ADDR == `ADDR_IRQ_FLAGS);
  assign wr_cfg   = WR_STB && (ADDR == `ADDR_TO_CONFIG);
  // A break must last longer than about eight bit times at the current rate
  assign break_min = divider_setting;

  // ==========================================================
  // Bit-rate generator: one tick every divider+1 clocks
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      baud_count <= '0;
      BIT_TICK   <= 1'b0;
    end else if (baud_count >= divider_setting) begin // see RULE_03
      baud_count <= '0;
      BIT_TICK   <= 1'b1;
    end else begin
      baud_count <= baud_count + DIV_WIDTH'(1);
      BIT_TICK   <= 1'b0;
    end
  end

  // ==========================================================
  // Break and sync acquisition (slave only)
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      state            <= lin_sync_pkg::SYNC_IDLE;
      low_count        <= '0;
      sync_span        <= '0;
      edges            <= '0;
      rxd_prev         <= 1'b1;
      sync_done        <= 1'b0;
      measured_divider <= '0;
      BREAK_ACTIVE     <= 1'b0;
    end else begin
      rxd_prev  <= RXD;
      sync_done <= 1'b0;
      case (state)
        lin_sync_pkg::SYNC_IDLE: begin
          BREAK_ACTIVE <= 1'b0;
          if (!RXD && !master_mode) begin // see RULE_02
            low_count <= '0;
            state     <= lin_sync_pkg::SYNC_BREAK;
          end
        end
        lin_sync_pkg::SYNC_BREAK: begin
          low_count <= low_count + (DIV_WIDTH+3)'(1);
          if (low_count[DIV_WIDTH+3-1:3] > (DIV_WIDTH)'(break_min)) begin
            BREAK_ACTIVE <= 1'b1;
          end
          if (rx_link.fault && break_exit_on_rx_fault) begin // see RULE_08
            BREAK_ACTIVE <= 1'b0;
            state        <= lin_sync_pkg::SYNC_IDLE;
          end else if (RXD) begin
            state <= BREAK_ACTIVE ? lin_sync_pkg::SYNC_WAIT : lin_sync_pkg::SYNC_IDLE;
          end
        end
        lin_sync_pkg::SYNC_WAIT: begin
          BREAK_ACTIVE <= 1'b0;
          if (rxd_prev && !RXD) begin // Start bit edge of sync byte
            // The edge cycle already counts, else the span is one clock short
            sync_span <= (DIV_WIDTH+3)'(1);
            edges     <= '0;
            state     <= lin_sync_pkg::SYNC_MEASURE;
          end
        end
        lin_sync_pkg::SYNC_MEASURE: begin
          sync_span <= sync_span + (DIV_WIDTH+3)'(1);
          if (rxd_prev && !RXD) begin
            edges <= edges + 4'h1;
            // Fifth falling edge ends eight bit times
            if (edges == 4'h3) begin
              measured_divider <= sync_span[DIV_WIDTH+3-1:3] - DIV_WIDTH'(1); // see RULE_01
              sync_done        <= 1'b1; // see RULE_04
              state            <= lin_sync_pkg::SYNC_IDLE;
            end
          end
          if (&sync_span) begin
            state <= lin_sync_pkg::SYNC_IDLE;
          end
        end
        default: state <= lin_sync_pkg::SYNC_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Divider setting: software write or automatic update
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      divider_setting <= `DIV_RESET;
    end else if (sync_done && auto_sync_update_enable && !master_mode) begin
      divider_setting <= measured_divider; // see RULE_06
    end else if (WR_STB && ADDR == `ADDR_DIV_HIGH) begin
      divider_setting[15:8] <= WDATA; // see RULE_05
    end else if (WR_STB && ADDR == `ADDR_DIV_LOW) begin
      divider_setting[7:0] <= WDATA;
    end
  end

  // ==========================================================
  // Interrupt flags: hardware set wins over write-one clear
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      flags <= `BYTE_ZERO;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (wr_flags && WDATA[i]) begin
          flags[i] <= 1'b0; // see RULE_13
        end
      end
      if (sync_done) begin
        flags[`FLG_RSI] <= 1'b1; // see RULE_04
        if (auto_sync_update_enable) begin
          flags[`FLG_AUTO_UPDATE_DONE_FLAG] <= 1'b1; // see RULE_06
        end
      end
    end
  end

  // ==========================================================
  // Timeout configuration and sticky fault flags
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      rx_stuck_fault_flag    <= 1'b0;
      tx_stuck_fault_flag    <= 1'b0;
      rx_stuck_irq_enable    <= 1'b0;
      tx_stuck_irq_enable    <= 1'b0;
      break_exit_on_rx_fault <= 1'b0;
      rx_stuck_timeout_value <= '0;
      tx_stuck_timeout_value <= '0;
      enables                <= `BYTE_ZERO;
      master_mode            <= 1'b0;
      auto_sync_update_enable <= 1'b0;
    end else begin
      if (wr_cfg) begin
        rx_stuck_timeout_value[0] <= WDATA[`CFG_RX_LSB]; // see RULE_07
        break_exit_on_rx_fault    <= WDATA[`CFG_BREAK_EXIT];
        rx_stuck_irq_enable       <= WDATA[`CFG_RX_EN];
        tx_stuck_irq_enable       <= WDATA[`CFG_TX_EN];
        if (WDATA[`CFG_RX_FLAG]) rx_stuck_fault_flag <= 1'b0; // see RULE_13
        if (WDATA[`CFG_TX_FLAG]) tx_stuck_fault_flag <= 1'b0;
      end
      if (rx_link.fault) rx_stuck_fault_flag <= 1'b1; // see RULE_09
      if (tx_link.fault) tx_stuck_fault_flag <= 1'b1; // see RULE_10
      if (WR_STB && ADDR == `ADDR_TX_TO_LOW)  tx_stuck_timeout_value[7:0]  <= WDATA;
      if (WR_STB && ADDR == `ADDR_TX_TO_HIGH) tx_stuck_timeout_value[15:8] <= WDATA;
      if (WR_STB && ADDR == `ADDR_RX_TO_LOW)  rx_stuck_timeout_value[8:1]  <= WDATA;
      if (WR_STB && ADDR == `ADDR_RX_TO_HIGH) rx_stuck_timeout_value[16:9] <= WDATA;
      if (WR_STB && ADDR == `ADDR_IRQ_ENABLES) enables <= WDATA;
      if (WR_STB && ADDR == `ADDR_MODE) begin
        master_mode             <= WDATA[`MODE_MASTER];
        auto_sync_update_enable <= WDATA[`MODE_AUTO_SYNC];
      end
    end
  end

  // ==========================================================
  // Interrupt output, registered
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(flags & enables) || (rx_stuck_fault_flag && rx_stuck_irq_enable)
             || (tx_stuck_fault_flag && tx_stuck_irq_enable); // see RULE_09
    end
  end

  // ==========================================================
  // Read port, data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      RDATA <= `BYTE_ZERO;
    end else if (RD_STB) begin
      case (ADDR)
        `ADDR_DIV_HIGH:    RDATA <= measured_divider[15:8]; // see RULE_01
        `ADDR_DIV_LOW:     RDATA <= measured_divider[7:0];
        `ADDR_IRQ_FLAGS:   RDATA <= flags;
        `ADDR_IRQ_ENABLES: RDATA <= enables;
        `ADDR_TO_CONFIG:   RDATA <= {rx_stuck_timeout_value[0], break_exit_on_rx_fault, 2'b00,
                                     rx_stuck_fault_flag, tx_stuck_fault_flag,
                                     rx_stuck_irq_enable, tx_stuck_irq_enable};
        `ADDR_TX_TO_LOW:   RDATA <= tx_stuck_timeout_value[7:0];
        `ADDR_TX_TO_HIGH:  RDATA <= tx_stuck_timeout_value[15:8];
        `ADDR_RX_TO_LOW:   RDATA <= rx_stuck_timeout_value[8:1];
        `ADDR_RX_TO_HIGH:  RDATA <= rx_stuck_timeout_value[16:9];
        `ADDR_MODE:        RDATA <= {6'h00, auto_sync_update_enable, master_mode};
        default:           RDATA <= `BYTE_ZERO;
      endcase
    end else begin
      RDATA <= `BYTE_ZERO;
    end
  end

  // ==========================================================
  // Checks
  property p_rx_flag_sticky;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      rx_link.fault |=> rx_stuck_fault_flag;
  endproperty
  a_rx_flag_sticky: assert property (p_rx_flag_sticky) else $error("rx fault flag not set"); // see RULE_09
  property p_tx_flag_sticky;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      tx_link.fault |=> tx_stuck_fault_flag;
  endproperty
  a_tx_flag_sticky: assert property (p_tx_flag_sticky) else $error("tx fault flag not set"); // see RULE_10
  property p_tx_hold;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      tx_stuck_fault_flag && !(wr_cfg && WDATA[`CFG_TX_FLAG]) |=> tx_stuck_fault_flag;
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx flag dropped"); // see RULE_13
  property p_rsi_set;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      sync_done |=> flags[`FLG_RSI];
  endproperty
  a_rsi_set: assert property (p_rsi_set) else $error("sync flag not set"); // see RULE_04
  property p_auto_copy;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      sync_done && auto_sync_update_enable && !master_mode |=> divider_setting == $past(measured_divider);
  endproperty
  a_auto_copy: assert property (p_auto_copy) else $error("auto update missing"); // see RULE_06
  property p_master_no_sync;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      master_mode && state == lin_sync_pkg::SYNC_IDLE |=> state == lin_sync_pkg::SYNC_IDLE;
  endproperty
  a_master_no_sync: assert property (p_master_no_sync) else $error("sync in master"); // see RULE_02
  property p_tick_period;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      BIT_TICK && divider_setting == 16'h0001 && $stable(divider_setting)
      |=> !BIT_TICK ##1 (BIT_TICK || divider_setting != 16'h0001);
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("bit tick period wrong"); // see RULE_03
  property p_rx_fault_no_recessive;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      rx_link.fault |-> $past(!RXD);
  endproperty
  a_rx_fault_no_recessive: assert property (p_rx_fault_no_recessive) else $error("rx fault while recessive"); // see RULE_12
  property p_break_exit;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      state == lin_sync_pkg::SYNC_BREAK && rx_link.fault && break_exit_on_rx_fault
      |=> state == lin_sync_pkg::SYNC_IDLE && !BREAK_ACTIVE;
  endproperty
  a_break_exit: assert property (p_break_exit) else $error("break not left on fault"); // see RULE_08
  c_sync: cover property (@(posedge CORE_CLK) disable iff (!RESET_N) sync_done);
  c_rx_fault: cover property (@(posedge CORE_CLK) disable iff (!RESET_N) rx_link.fault);
  c_tx_fault: cover property (@(posedge CORE_CLK) disable iff (!RESET_N) tx_link.fault);
  c_irq: cover property (@(posedge CORE_CLK) disable iff (!RESET_N) IRQ);
endmodule : lin_sync_top
`default_nettype wire

//--- lin_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// ======================================================
// Master node on the single-wire bus
// ======================================================
module lin_master_model (
  input  wire logic clk,
  output var  logic rxd
);
  // Bus has a pull-up: recessive (1) whenever nobody pulls it down
  initial rxd = 1'b1;

  // Dominant level for n clocks, then release
  task automatic hold_low(input int n);
    @(posedge clk);
    rxd <= 1'b0;
    repeat (n) @(posedge clk);
    rxd <= 1'b1;
  endtask : hold_low

  // Break, delimiter, then a sync byte 0x55 with start and stop bits
  task automatic send_header(input int bit_clks);
    logic [9:0] frame;
    int         i;
    frame = {1'b1, 8'h55, 1'b0};
    hold_low(13 * bit_clks);
    repeat (bit_clks) @(posedge clk);
    for (i = 0; i < 10; i++) begin
      rxd <= frame[i];
      repeat (bit_clks) @(posedge clk);
    end
    rxd <= 1'b1;
  endtask : send_header
endmodule : lin_master_model
`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ======================================================
  // Signals and instances
  // ======================================================
  typedef struct packed {logic [15:0] addr; logic [7:0] wdata; logic [7:0] rst; logic [7:0] exp;} row_type;
  logic        CORE_CLK;
  logic        RESET_N;
  logic [15:0] ADDR;
  logic [7:0]  WDATA;
  logic        WR_STB;
  logic        RD_STB;
  logic [7:0]  RDATA;
  logic        RXD;
  logic        TXD;
  logic        BIT_TICK;
  logic        BREAK_ACTIVE;
  logic        IRQ;
  int          fail_count = 0;
  int          samples_checked = 0;
  int          i;
  // Address, write value, value after reset, value read back
  row_type rows [8] = '{'{16'hA095, 8'hFF, 8'h00, 8'h00}, '{16'hA096, 8'h5A, 8'h00, 8'h5A},
    '{16'hA0A0, 8'hFF, 8'h00, 8'hC3}, '{16'hA0A1, 8'h5A, 8'h00, 8'h5A}, '{16'hA0A2, 8'hA5, 8'h00, 8'hA5},
    '{16'hA0A3, 8'h3C, 8'h00, 8'h3C}, '{16'hA0B5, 8'hFF, 8'h00, 8'h00}, '{16'hA0A4, 8'h01, 8'h00, 8'h01}};

  lin_sync_top DUT (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .ADDR(ADDR), .WDATA(WDATA), .WR_STB(WR_STB),
    .RD_STB(RD_STB), .RDATA(RDATA), .RXD(RXD), .TXD(TXD), .BIT_TICK(BIT_TICK),
    .BREAK_ACTIVE(BREAK_ACTIVE), .IRQ(IRQ));
  lin_master_model master_node (.clk(CORE_CLK), .rxd(RXD));

  // ======================================================
  // Helpers
  // ======================================================
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_byte

  task automatic check_bit(input logic got, input logic exp);
    check_byte({7'h00, got}, {7'h00, exp});
  endtask : check_bit

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge CORE_CLK);
    ADDR   <= a;
    WDATA  <= d;
    WR_STB <= 1'b1;
    @(posedge CORE_CLK);
    WR_STB <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    @(posedge CORE_CLK);
    ADDR   <= a;
    RD_STB <= 1'b1;
    @(posedge CORE_CLK);
    RD_STB <= 1'b0;
    #1;
    check_byte(RDATA, exp);
  endtask : rd_chk

  // Clocks from one tick to the next
  task automatic tick_gap(input logic [7:0] exp);
    int n;
    #1;
    n = 0;
    while (BIT_TICK !== 1'b1 && n < 300) begin
      @(posedge CORE_CLK);
      #1;
      n++;
    end
    n = 0;
    do begin
      @(posedge CORE_CLK);
      #1;
      n++;
    end while (BIT_TICK !== 1'b1 && n < 300);
    check_byte(n[7:0], exp);
  endtask : tick_gap

  task automatic wait_irq(input logic lvl);
    int k;
    #1;
    for (k = 0; k < 400 && IRQ !== lvl; k++) begin
      @(posedge CORE_CLK);
      #1;
    end
    check_bit(IRQ, lvl);
  endtask : wait_irq

  task automatic wait_brk;
    int k;
    #1;
    for (k = 0; k < 300 && BREAK_ACTIVE !== 1'b1; k++) begin
      @(posedge CORE_CLK);
      #1;
    end
    check_bit(BREAK_ACTIVE, 1'b1);
  endtask : wait_brk

  // Transmit line dominant for n sampled clocks
  task automatic tx_low(input int n);
    @(posedge CORE_CLK);
    TXD <= 1'b0;
    repeat (n) @(posedge CORE_CLK);
    TXD <= 1'b1;
  endtask : tx_low

  task automatic end_of_test;
    if (fail_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  // ======================================================
  // Clock, watchdog and main sequence
  // ======================================================
  initial begin
    CORE_CLK = 1'b0;
    forever #5 CORE_CLK = ~CORE_CLK;
  end

  // Whole run needs roughly 2300 clocks; allow a wide margin
  initial begin
    #500000;
    fail_count++;
    end_of_test();
  end

  initial begin
    RESET_N = 1'b0;
    ADDR    = 16'h0000;
    WDATA   = 8'h00;
    WR_STB  = 1'b0;
    RD_STB  = 1'b0;
    TXD     = 1'b1;
    repeat (20) @(posedge CORE_CLK);
    RESET_N <= 1'b1;
    #1;
    check_bit(IRQ, 1'b0);
    for (i = 0; i < 8; i++) begin
      rd_chk(rows[i].addr, rows[i].rst);
      wr(rows[i].addr, rows[i].wdata);
      rd_chk(rows[i].addr, rows[i].exp);
    end
    wr(16'hA0A0, 8'h00);
    wr(16'hA0A2, 8'h00);
    wr(16'hA0A1, 8'h02);
    wr(16'hA096, 8'h02);
    tick_gap(8'h02);
    // Slow the slave down so that short dominant data bits never pass as a break
    wr(16'hA094, 8'h10);
    tick_gap(8'h11);
    // Slave header, bit time 20 clocks: measured divider 19
    fork
      master_node.send_header(20);
      wait_brk();
    join
    wait_irq(1'b1);
    rd_chk(16'hA095, 8'h02);
    rd_chk(16'hA093, 8'h00);
    rd_chk(16'hA094, 8'h13);
    wr(16'hA095, 8'h00);
    rd_chk(16'hA095, 8'h02);
    wr(16'hA095, 8'h02);
    rd_chk(16'hA095, 8'h00);
    wait_irq(1'b0);
    // Software copy; divider is never written as zero
    wr(16'hA093, 8'h00);
    wr(16'hA094, 8'h13);
    tick_gap(8'h14);
    // Automatic update, bit time 16 clocks: break still longer than eight bit times
    wr(16'hA0B0, 8'h02);
    wr(16'hA096, 8'h0A);
    master_node.send_header(16);
    wait_irq(1'b1);
    rd_chk(16'hA095, 8'h0A);
    rd_chk(16'hA094, 8'h0F);
    tick_gap(8'h10);
    wr(16'hA095, 8'h0A);
    // Master operation: no measurement, old value kept
    wr(16'hA0B0, 8'h01);
    master_node.send_header(30);
    rd_chk(16'hA095, 8'h00);
    rd_chk(16'hA094, 8'h0F);
    wr(16'hA0B0, 8'h00);
    // Transmit fault, limit 2: three dominant clocks needed; stale receive flag cleared
    wr(16'hA0A0, 8'h09);
    tx_low(2);
    rd_chk(16'hA0A0, 8'h01);
    tx_low(3);
    wait_irq(1'b1);
    rd_chk(16'hA0A0, 8'h05);
    wr(16'hA0A0, 8'h05);
    rd_chk(16'hA0A0, 8'h01);
    wait_irq(1'b0);
    wr(16'hA0A0, 8'h00);
    tx_low(3);
    rd_chk(16'hA0A0, 8'h04);
    check_bit(IRQ, 1'b0);
    wr(16'hA0A0, 8'h04);
    // Receive fault, limit 0x101, break exit on; break qualifies first
    wr(16'hA0A4, 8'h00);
    wr(16'hA0A3, 8'h80);
    wr(16'hA0A0, 8'hC2);
    fork
      master_node.hold_low(400);
      begin
        wait_brk();
        wait_irq(1'b1);
        repeat (2) @(posedge CORE_CLK);
        #1;
        check_bit(BREAK_ACTIVE, 1'b0);
      end
    join
    rd_chk(16'hA0A0, 8'hCA);
    wr(16'hA0A0, 8'hCA);
    rd_chk(16'hA0A0, 8'hC2);
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
